/* core/gpf_pkg.sv */
package gpf_pkg;

    // octet values presented toward the mac
    localparam logic [7:0] GPF_PREAMBLE = 8'h55;
    localparam logic [7:0] GPF_JAM = 8'h55;
    localparam logic [7:0] GPF_FALSE_CAR = 8'h0e;
    localparam logic [7:0] GPF_EXT_OCT = 8'h0f;
    localparam logic [7:0] GPF_EXT_ERR_OCT = 8'h1f;

    // clocks and timing
    localparam int GPF_CORE_HZ = 20_000_000;
    localparam int GPF_LINK_HZ = 8_000_000;
    localparam int GPF_LOCK_NS = 15_000;
    localparam int GPF_LOCK_CYC = GPF_LOCK_NS / (1_000_000_000 / GPF_LINK_HZ);

    // descrambler
    localparam int GPF_LFSR_W = 33;
    localparam int GPF_LFSR_TAP = 13;
    localparam int GPF_CNT_W = 7;
    localparam int GPF_MATCH_CYC = GPF_LOCK_CYC - GPF_LFSR_W;

    // burst and frame sizes in octets, burst counter width in bits
    localparam int GPF_BURST_BYTES = 8192;
    localparam int GPF_JUMBO_BYTES = 10240;
    localparam int GPF_BURST_W = 14;

    typedef enum logic [2:0] {
        SYM_IDLE = 3'h0,
        SYM_SSD = 3'h1,
        SYM_DATA = 3'h2,
        SYM_CSR = 3'h3,
        SYM_ESD = 3'h4,
        SYM_ERR = 3'h5,
        SYM_EXT = 3'h6,
        SYM_EXT_ERR = 3'h7
    } gpf_sym_e;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_SSD1 = 3'h1,
        TX_SSD2 = 3'h2,
        TX_DATA = 3'h3,
        TX_CSR2 = 3'h4,
        TX_ESD1 = 3'h5,
        TX_ESD2 = 3'h6,
        TX_EXT = 3'h7
    } gpf_tx_st_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'h0,
        RX_PRE2 = 3'h1,
        RX_DATA = 3'h2,
        RX_TAIL = 3'h3,
        RX_FALSE = 3'h4
    } gpf_rx_st_e;

    // ten-bit code tables, negative running disparity column
    localparam logic [5:0] GPF_6B_TBL [32] = '{
        6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] GPF_4B_TBL [8] = '{
        4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

    // returns {running disparity after, ten-bit code}
    function automatic logic [10:0] gpf_enc8b10b(input logic [7:0] d, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic r;
        logic [4:0] x;
        s6 = GPF_6B_TBL[d[4:0]];
        x = d[4:0];
        r = rd;
        if ($countones(s6) != 3) begin
            if (r) s6 = ~s6;
            r = ~r;
        end else if (x == 5'h07 && r) begin
            s6 = 6'h07;
        end
        s4 = GPF_4B_TBL[d[7:5]];
        if (d[7:5] == 3'h7 && ((!r && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
                (r && (x == 5'h0b || x == 5'h0d || x == 5'h0e)))) begin
            s4 = 4'h7;
        end
        if ($countones(s4) != 2) begin
            if (r) s4 = ~s4;
            r = ~r;
        end else if (d[7:5] == 3'h3 && r) begin
            s4 = 4'h3;
        end
        return {r, s6, s4};
    endfunction : gpf_enc8b10b

endpackage : gpf_pkg

/* core/gpf_rx_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface gpf_rx_if;
    logic rx_dv;
    logic rx_er;
    logic [7:0] rxd;
    logic tbi_mode;
    modport src (output rx_dv, output rx_er, output rxd, output tbi_mode);
    modport conv (input rx_dv, input rx_er, input rxd, input tbi_mode);
endinterface : gpf_rx_if
`default_nettype wire

/* core/gpf_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module gpf_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // level in and synchronised level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : gpf_sync
`default_nettype wire

/* core/gpf_tbi_enc.sv */
`timescale 1ns/1ps
`default_nettype none
module gpf_tbi_enc
    import gpf_pkg::*;
(
    // receive clock and reset
    input wire logic link_clk,
    input wire logic arst_n,
    // octet stream from the receive framer
    gpf_rx_if.conv rxb,
    // ten-bit code toward the mac
    output logic [9:0] rx_code
);
    logic rd;
    logic [10:0] enc;

    assign enc = gpf_enc8b10b(rxb.rxd, rd);

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd <= 1'b0;
            rx_code <= '0;
        end else if (rxb.tbi_mode) begin
            rd <= enc[10];
            rx_code <= enc[9:0];
        end else begin
            rd <= 1'b0;
            rx_code <= '0;
        end
    end
endmodule : gpf_tbi_enc
`default_nettype wire

/* core/gpf_frame_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - on frame start raise carrier sense and send two start delimiters
// - after enable drops send two resets, two end delimiters, then idle
// - on received start delimiter assert valid and deliver two preamble octets
// - drop valid and carrier sense on the first received reset symbol
// - half duplex: transmit during partner activity gives collision and jam
// - activity without start delimiter is false carrier, error with 0e
// - transmit error during enable sends error codes, ignores data
// - receive error held exactly as long as error codes arrive
// - extension closes frame then sends carrier-extend symbols
// - error dropping alone during extension gives idle at once
// - enable rising as error falls: finish closing, then new start delimiter
// - carrier sense stays high while enable or error is high
// - received extension drops valid, raises error and shows 0f
// - carrier sense high whenever receive valid or error is high
// - extension octet other than 0f sends extend-with-error symbols
// - received extend-with-error raises error and shows 1f
// - half duplex bursts up to 8 KB, gaps filled with extend symbols
// - full duplex frames up to 10 KB pass, 200 ppm clock offset
// - descrambler loads 33-bit seed from idles, locks within about 15 us
// - ten-bit mode encodes receive octets, bypassed in byte mode
// - ten-bit mode decodes transmit data codes, ignores others
// - one octet per clock on both mac port and line coder
module gpf_frame_ctrl
    import gpf_pkg::*;
#(
    parameter int BURST_LIMIT = GPF_BURST_BYTES
) (
    // clocks and reset
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic link_clk,
    // configuration pins
    input wire logic half_duplex,
    input wire logic tbi_mode,
    // mac transmit
    input wire logic tx_en,
    input wire logic tx_er,
    input wire logic [7:0] txd,
    input wire logic [9:0] tx_code,
    // mac status
    output logic crs,
    output logic col,
    // mac receive
    output logic rx_dv,
    output logic rx_er,
    output logic [7:0] rxd,
    output logic [9:0] rx_code,
    // line symbols out, core clock
    output gpf_sym_e line_tx_kind,
    output logic [7:0] line_tx_data,
    // line symbols in, link clock
    input wire gpf_sym_e line_rx_kind,
    input wire logic [7:0] line_rx_data,
    // descrambler state
    output logic scr_locked
);
    localparam logic [GPF_CNT_W-1:0] SEED_N = GPF_CNT_W'(GPF_LFSR_W);
    localparam logic [GPF_CNT_W-1:0] MATCH_N = GPF_CNT_W'(GPF_MATCH_CYC);
    localparam logic [GPF_BURST_W-1:0] BURST_N = GPF_BURST_W'(BURST_LIMIT);

    gpf_tx_st_e tx_st;
    gpf_rx_st_e rx_st;
    logic concat;
    logic [GPF_BURST_W-1:0] burst_cnt;
    logic [7:0] last_oct;
    logic [7:0] dec_oct;
    logic dec_hit;
    logic [7:0] txd_eff;
    logic tbi_core;
    logic rx_act_core;
    logic half_link;
    logic txen_link;
    logic tbi_link;
    logic rx_act;
    logic coll;
    logic [GPF_LFSR_W-1:0] lfsr;
    logic lfsr_pred;
    logic [GPF_CNT_W-1:0] seed_cnt;
    logic [GPF_CNT_W-1:0] match_cnt;
    logic [10:0] cand0;
    logic [10:0] cand1;

    gpf_rx_if rxb ();

    // crossings into the core domain
    gpf_sync #(.W(2)) u_sync_core (
        .clk(core_clk),
        .arst_n(arst_n),
        .d({tbi_mode, rx_act}),
        .q({tbi_core, rx_act_core})
    );

    // crossings into the link domain
    gpf_sync #(.W(3)) u_sync_link (
        .clk(link_clk),
        .arst_n(arst_n),
        .d({half_duplex, tx_en, tbi_mode}),
        .q({half_link, txen_link, tbi_link})
    );

    always_comb begin
        dec_hit = 1'b0;
        dec_oct = last_oct;
        cand0 = '0;
        cand1 = '0;
        for (int i = 0; i < 256; i++) begin
            cand0 = gpf_enc8b10b(8'(i), 1'b0);
            cand1 = gpf_enc8b10b(8'(i), 1'b1);
            if (!dec_hit && (cand0[9:0] == tx_code || cand1[9:0] == tx_code)) begin
                dec_hit = 1'b1;
                dec_oct = 8'(i);
            end
        end
    end

    assign txd_eff = tbi_core ? dec_oct : txd;

    // non-data codes repeat the last decoded octet
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_oct <= '0;
        end else if (tbi_core && dec_hit) begin
            last_oct <= dec_oct;
        end
    end

    // one symbol per clock out of the transmit framer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_st <= TX_IDLE;
            line_tx_kind <= SYM_IDLE;
            line_tx_data <= '0;
        end else begin
            line_tx_kind <= SYM_IDLE;
            line_tx_data <= '0;
            case (tx_st)
                TX_IDLE: begin
                    if (tx_en) begin
                        line_tx_kind <= SYM_SSD;
                        tx_st <= TX_SSD2;
                    end
                end
                TX_SSD1: begin
                    line_tx_kind <= SYM_SSD;
                    tx_st <= TX_SSD2;
                end
                TX_SSD2: begin
                    line_tx_kind <= SYM_SSD;
                    tx_st <= TX_DATA;
                end
                TX_DATA: begin
                    if (tx_en && tx_er) begin
                        line_tx_kind <= SYM_ERR;
                    end else if (tx_en) begin
                        line_tx_kind <= SYM_DATA;
                        line_tx_data <= txd_eff;
                    end else begin
                        line_tx_kind <= SYM_CSR;
                        tx_st <= TX_CSR2;
                    end
                end
                TX_CSR2: begin
                    line_tx_kind <= SYM_CSR;
                    tx_st <= TX_ESD1;
                end
                TX_ESD1: begin
                    line_tx_kind <= SYM_ESD;
                    tx_st <= TX_ESD2;
                end
                TX_ESD2: begin
                    line_tx_kind <= SYM_ESD;
                    if (tx_en || concat) begin
                        tx_st <= TX_SSD1;
                    end else if (tx_er) begin
                        tx_st <= TX_EXT;
                    end else begin
                        tx_st <= TX_IDLE;
                    end
                end
                TX_EXT: begin
                    // burst length cap releases the link
                    if (burst_cnt >= BURST_N) begin
                        tx_st <= TX_IDLE;
                    end else if (tx_en) begin
                        line_tx_kind <= SYM_SSD;
                        tx_st <= TX_SSD2;
                    end else if (tx_er) begin
                        line_tx_kind <= (txd_eff == GPF_EXT_OCT) ? SYM_EXT : SYM_EXT_ERR;
                    end else begin
                        tx_st <= TX_IDLE;
                    end
                end
                default: begin
                    tx_st <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            concat <= 1'b0;
        end else if (tx_st == TX_CSR2 || tx_st == TX_ESD1 || tx_st == TX_ESD2) begin
            concat <= concat | tx_en;
        end else begin
            concat <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_cnt <= '0;
        end else if (tx_st == TX_IDLE) begin
            burst_cnt <= '0;
        end else if (burst_cnt != '1) begin
            burst_cnt <= burst_cnt + 1'b1;
        end
    end

    // carrier sense from transmit and received activity
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            crs <= 1'b0;
        end else begin
            crs <= tx_en | tx_er | (tx_st != TX_IDLE) | rx_act_core;
        end
    end

    assign coll = half_link && txen_link && (line_rx_kind != SYM_IDLE);
    // receive carrier from valid or error
    assign rx_act = rx_dv | rx_er;

    // receive framer on the receive clock
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st <= RX_IDLE;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd <= '0;
            col <= 1'b0;
        end else begin
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd <= '0;
            col <= coll;
            case (rx_st)
                RX_IDLE, RX_TAIL: begin
                    case (line_rx_kind)
                        SYM_SSD: begin
                            rx_dv <= 1'b1;
                            rxd <= GPF_PREAMBLE;
                            rx_st <= RX_PRE2;
                        end
                        SYM_IDLE: begin
                            rx_st <= RX_IDLE;
                        end
                        SYM_EXT: begin
                            rx_er <= 1'b1;
                            rxd <= GPF_EXT_OCT;
                        end
                        SYM_EXT_ERR: begin
                            rx_er <= 1'b1;
                            rxd <= GPF_EXT_ERR_OCT;
                        end
                        default: begin
                            if (rx_st == RX_IDLE) begin
                                rx_er <= 1'b1;
                                rxd <= GPF_FALSE_CAR;
                                rx_st <= RX_FALSE;
                            end
                        end
                    endcase
                end
                RX_PRE2: begin
                    rx_dv <= 1'b1;
                    rxd <= GPF_PREAMBLE;
                    rx_st <= RX_DATA;
                end
                RX_DATA: begin
                    case (line_rx_kind)
                        SYM_DATA: begin
                            rx_dv <= 1'b1;
                            rxd <= line_rx_data;
                        end
                        SYM_ERR: begin
                            rx_dv <= 1'b1;
                            rx_er <= 1'b1;
                            rxd <= line_rx_data;
                        end
                        SYM_EXT: begin
                            rx_er <= 1'b1;
                            rxd <= GPF_EXT_OCT;
                            rx_st <= RX_TAIL;
                        end
                        SYM_EXT_ERR: begin
                            rx_er <= 1'b1;
                            rxd <= GPF_EXT_ERR_OCT;
                            rx_st <= RX_TAIL;
                        end
                        default: begin
                            rx_st <= RX_TAIL;
                        end
                    endcase
                end
                RX_FALSE: begin
                    if (line_rx_kind != SYM_IDLE) begin
                        rx_er <= 1'b1;
                        rxd <= GPF_FALSE_CAR;
                    end else begin
                        rx_st <= RX_IDLE;
                    end
                end
                default: begin
                    rx_st <= RX_IDLE;
                end
            endcase
            if (coll) begin
                rxd <= GPF_JAM;
            end
        end
    end

    assign lfsr_pred = lfsr[GPF_LFSR_W-1] ^ lfsr[GPF_LFSR_TAP-1];

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lfsr <= '0;
            seed_cnt <= '0;
            match_cnt <= '0;
            scr_locked <= 1'b0;
        end else if (seed_cnt != SEED_N) begin
            if (line_rx_kind == SYM_IDLE) begin
                lfsr <= {lfsr[GPF_LFSR_W-2:0], line_rx_data[0]};
                seed_cnt <= seed_cnt + 1'b1;
            end else begin
                seed_cnt <= '0;
            end
        end else begin
            lfsr <= {lfsr[GPF_LFSR_W-2:0], lfsr_pred};
            if (line_rx_kind == SYM_IDLE && line_rx_data[0] != lfsr_pred) begin
                seed_cnt <= '0;
                match_cnt <= '0;
                scr_locked <= 1'b0;
            end else if (match_cnt != MATCH_N) begin
                match_cnt <= match_cnt + 1'b1;
            end else begin
                scr_locked <= 1'b1;
            end
        end
    end

    assign rxb.rx_dv = rx_dv;
    assign rxb.rx_er = rx_er;
    assign rxb.rxd = rxd;
    assign rxb.tbi_mode = tbi_link;

    gpf_tbi_enc u_tbi (
        .link_clk(link_clk),
        .arst_n(arst_n),
        .rxb(rxb),
        .rx_code(rx_code)
    );

    sequence s_two_ssd;
        line_tx_kind == SYM_SSD ##1 line_tx_kind == SYM_SSD;
    endsequence
    sequence s_close;
        line_tx_kind == SYM_CSR ##1 line_tx_kind == SYM_CSR
            ##1 line_tx_kind == SYM_ESD ##1 line_tx_kind == SYM_ESD;
    endsequence

    chk_tx_start_ssd: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (tx_st == TX_IDLE && tx_en) |=> s_two_ssd ##0 crs)
        else $error("frame start did not give two delimiters");
    chk_tx_close_seq: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (tx_st == TX_DATA && !tx_en) |=> s_close)
        else $error("frame close sequence wrong");
    chk_tx_error_code: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (tx_st == TX_DATA && tx_en && tx_er) |=> line_tx_kind == SYM_ERR)
        else $error("error code not sent");
    chk_ext_to_idle: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (tx_st == TX_EXT && !tx_en && !tx_er) |=> line_tx_kind == SYM_IDLE && tx_st == TX_IDLE)
        else $error("extension end not idle");
    chk_concat_ssd: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (tx_st == TX_ESD2 && tx_en) |=> line_tx_kind == SYM_ESD ##1 s_two_ssd)
        else $error("concatenation did not restart");
    chk_crs_hold: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        (tx_en || tx_er) |=> crs)
        else $error("carrier sense low during transmit");
    chk_rx_preamble: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (rx_st == RX_IDLE && line_rx_kind == SYM_SSD)
            |=> (rx_dv && rxd == GPF_PREAMBLE) [*2])
        else $error("preamble not substituted");
    chk_rx_reset_drop: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (rx_st == RX_DATA && line_rx_kind == SYM_CSR) |=> !rx_dv && !rx_er)
        else $error("valid not dropped on reset symbol");
    chk_col_jam: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        coll |=> col && rxd == GPF_JAM)
        else $error("collision without jam");
    chk_false_carrier: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (rx_st == RX_IDLE && line_rx_kind == SYM_DATA && !coll)
            |=> rx_er && !rx_dv && rxd == GPF_FALSE_CAR)
        else $error("false carrier not flagged");
    chk_rx_ext_err: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (rx_st inside {RX_DATA, RX_TAIL} && line_rx_kind == SYM_EXT_ERR && !coll)
            |=> rx_er && !rx_dv && rxd == GPF_EXT_ERR_OCT)
        else $error("extend with error not shown");
    chk_lock_loss: assert property (
        @(posedge link_clk) disable iff (!arst_n)
        (seed_cnt == SEED_N && line_rx_kind == SYM_IDLE && line_rx_data[0] != lfsr_pred)
            |=> !scr_locked && seed_cnt == '0)
        else $error("lock kept after mismatch");

endmodule : gpf_frame_ctrl
`default_nettype wire

/* tb/gpf_line_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module gpf_line_peer
    import gpf_pkg::*;
(
    // link clock and reset
    input wire logic link_clk,
    input wire logic arst_n,
    // symbol asked for by the bench
    input wire gpf_sym_e sym,
    input wire logic [7:0] dat,
    input wire logic flip,
    // symbol on the line
    output var gpf_sym_e kind,
    output logic [7:0] data
);
    logic [GPF_LFSR_W-1:0] fill;
    // scrambled idle bits from the same recurrence as the far transmitter
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill <= 33'h01d2c3b4a;
        end else begin
            fill <= {fill[GPF_LFSR_W-2:0], fill[GPF_LFSR_W-1] ^ fill[GPF_LFSR_TAP-1]};
        end
    end
    assign kind = sym;
    // flip spoils one idle bit to break descrambler lock
    assign data = (sym == SYM_DATA || sym == SYM_ERR) ? dat : {fill[7:1], fill[0] ^ flip};
endmodule : gpf_line_peer
`default_nettype wire

/* tb/test_gpf_frame_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module test_gpf_frame_ctrl
    import gpf_pkg::*;
;
    logic core_clk = 0, link_clk = 0, arst_n = 0, half_duplex = 0, tbi_mode = 0, flip = 0;
    logic tx_en = 0, tx_er = 0, crs, col, rx_dv, rx_er, scr_locked;
    logic [7:0] txd = 0, dat = 0, rxd, line_tx_data, line_rx_data;
    logic [9:0] tx_code = 0, rx_code;
    gpf_sym_e sym = SYM_IDLE, line_rx_kind, line_tx_kind;
    int n_mismatch = 0, tests_run = 0;
    always #25 core_clk = ~core_clk;
    always #62.5 link_clk = ~link_clk;
    gpf_frame_ctrl #(.BURST_LIMIT(64)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .link_clk(link_clk), .half_duplex(half_duplex), .tbi_mode(tbi_mode),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .tx_code(tx_code), .crs(crs),
        .col(col), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .rx_code(rx_code),
        .line_tx_kind(line_tx_kind), .line_tx_data(line_tx_data),
        .line_rx_kind(line_rx_kind), .line_rx_data(line_rx_data), .scr_locked(scr_locked));
    gpf_line_peer peer (.link_clk(link_clk), .arst_n(arst_n), .sym(sym), .dat(dat),
        .flip(flip), .kind(line_rx_kind), .data(line_rx_data));
    task automatic chk(input logic [9:0] s, input logic [9:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic conclude;
        $display("mismatches %0d of %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    // drive one transmit cycle, check the symbol from the last one
    task automatic st(input logic [1:0] c, input logic [7:0] d, input gpf_sym_e k,
            input logic [7:0] kd);
        @(posedge core_clk);
        tx_en <= c[1];
        tx_er <= c[0];
        txd <= d;
        #1;
        chk(line_tx_kind, k);
        chk(line_tx_data, kd);
    endtask : st
    task automatic tx_frame(input logic ext, input logic [7:0] xd, input gpf_sym_e xk);
        st(2, 8'h55, SYM_IDLE, 0);
        st(2, 8'h55, SYM_SSD, 0);
        chk(crs, 1);
        st(2, 8'ha1, SYM_SSD, 0);
        st(3, 8'h77, SYM_DATA, 8'ha1);
        st(2, 8'ha3, SYM_ERR, 0);
        st({1'b0, ext}, xd, SYM_DATA, 8'ha3);
        for (int i = 0; i < 4; i++) st({1'b0, ext}, xd, i < 2 ? SYM_CSR : SYM_ESD, 0);
        st(0, 0, xk, 0);
        if (ext) chk(crs, 1);
        st(0, 0, SYM_IDLE, 0);
    endtask : tx_frame
    // drive one line symbol, check the outputs for the last one
    task automatic rs(input gpf_sym_e s, input logic [7:0] d, input logic dv,
            input logic er, input logic [7:0] rd);
        @(posedge link_clk);
        sym <= s;
        dat <= d;
        #1;
        chk(rx_dv, dv);
        chk(rx_er, er);
        if (rd !== 8'hxx) chk(rxd, rd);
    endtask : rs
    task automatic rx_frame;
        rs(SYM_SSD, 0, 0, 0, 8'hxx);
        rs(SYM_SSD, 0, 1, 0, 8'h55);
        rs(SYM_DATA, 8'h3c, 1, 0, 8'h55);
        chk(rx_code, 0);
        rs(SYM_ERR, 0, 1, 0, 8'h3c);
        chk(crs, 1);
        rs(SYM_DATA, 8'h4d, 1, 1, 8'hxx);
        rs(SYM_CSR, 0, 1, 0, 8'h4d);
        rs(SYM_CSR, 0, 0, 0, 8'hxx);
        rs(SYM_ESD, 0, 0, 0, 8'hxx);
        rs(SYM_ESD, 0, 0, 0, 8'hxx);
        rs(SYM_EXT, 0, 0, 0, 8'hxx);
        rs(SYM_EXT_ERR, 0, 0, 1, 8'h0f);
        rs(SYM_IDLE, 0, 0, 1, 8'h1f);
        rs(SYM_DATA, 8'h12, 0, 0, 8'hxx);
        rs(SYM_DATA, 8'h34, 0, 1, 8'h0e);
        rs(SYM_IDLE, 0, 0, 1, 8'h0e);
        rs(SYM_IDLE, 0, 0, 0, 8'hxx);
    endtask : rx_frame
    task automatic rx_col;
        @(posedge core_clk);
        half_duplex <= 1'b1;
        tx_en <= 1'b1;
        repeat (4) rs(SYM_IDLE, 0, 0, 0, 8'hxx);
        rs(SYM_SSD, 0, 0, 0, 8'hxx);
        rs(SYM_SSD, 0, 1, 0, 8'h55);
        rs(SYM_DATA, 8'h3c, 1, 0, 8'h55);
        rs(SYM_IDLE, 0, 1, 0, 8'h55);
        chk(col, 1);
        @(posedge core_clk);
        tx_en <= 1'b0;
        half_duplex <= 1'b0;
        repeat (12) @(posedge core_clk);
    endtask : rx_col
    task automatic rx_lock;
        @(posedge link_clk);
        #1;
        chk(scr_locked, 0);
        repeat (125) @(posedge link_clk);
        #1;
        chk(scr_locked, 1);
        @(posedge link_clk);
        flip <= 1'b1;
        @(posedge link_clk);
        flip <= 1'b0;
        #1;
        chk(scr_locked, 0);
    endtask : rx_lock
    task automatic tx_concat;
        st(2, 8'h55, SYM_IDLE, 0);
        st(2, 8'h55, SYM_SSD, 0);
        st(2, 8'h61, SYM_SSD, 0);
        st(1, 8'h0f, SYM_DATA, 8'h61);
        st(1, 8'h0f, SYM_CSR, 0);
        for (int i = 0; i < 3; i++) st(2, 8'h55, i < 1 ? SYM_CSR : SYM_ESD, 0);
        st(2, 8'h55, SYM_SSD, 0);
        chk(crs, 1);
        st(2, 8'h72, SYM_SSD, 0);
        st(0, 0, SYM_DATA, 8'h72);
        for (int i = 0; i < 4; i++) st(0, 0, i < 2 ? SYM_CSR : SYM_ESD, 0);
        st(0, 0, SYM_IDLE, 0);
    endtask : tx_concat
    task automatic tx_burst;
        st(2, 8'h55, SYM_IDLE, 0);
        st(2, 8'h55, SYM_SSD, 0);
        st(2, 8'h55, SYM_SSD, 0);
        st(1, 8'h0f, SYM_DATA, 8'h55);
        for (int i = 0; i < 4; i++) st(1, 8'h0f, i < 2 ? SYM_CSR : SYM_ESD, 0);
        repeat (58) st(1, 8'h0f, SYM_EXT, 0);
        st(1, 8'h0f, SYM_IDLE, 0);
        st(0, 0, SYM_IDLE, 0);
    endtask : tx_burst
    task automatic tbi_path;
        @(posedge core_clk);
        tbi_mode <= 1'b1;
        tx_code <= 10'h2aa;
        repeat (4) @(posedge core_clk);
        tx_code <= 10'h0fa;
        tx_en <= 1'b1;
        st(2, 0, SYM_SSD, 0);
        st(2, 0, SYM_SSD, 0);
        st(0, 0, SYM_DATA, 8'hb5);
        repeat (5) @(posedge core_clk);
        rs(SYM_SSD, 0, 0, 0, 8'hxx);
        rs(SYM_SSD, 0, 1, 0, 8'h55);
        rs(SYM_DATA, 8'hb5, 1, 0, 8'h55);
        rs(SYM_CSR, 0, 1, 0, 8'hb5);
        chk(rx_code, 10'h2a5);
        rs(SYM_CSR, 0, 0, 0, 8'hxx);
        chk(rx_code, 10'h2aa);
    endtask : tbi_path
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge link_clk);
        tx_frame(0, 8'h00, SYM_IDLE);
        tx_frame(1, 8'h0f, SYM_EXT);
        tx_frame(1, 8'h33, SYM_EXT_ERR);
        rx_frame();
        rx_col();
        rx_lock();
        tx_concat();
        tx_burst();
        tbi_path();
        conclude();
    end
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule : test_gpf_frame_ctrl
`default_nettype wire
